//--- logic/fcs_pkg.sv
package fcs_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;

  // ==========================================================================
  // Command cycle addresses and data codes
  localparam logic [19:0] A_UNLK1 = 20'h00555;
  localparam logic [19:0] A_UNLK2 = 20'h00AAA;
  localparam logic [19:0] A_QUERY = 20'h00055;
  localparam logic [19:0] A_LOCKSTAT = 20'h00080;
  localparam logic [19:0] A_ZERO = 20'h00000;
  localparam logic [7:0] D_UNLK1 = 8'hAA;
  localparam logic [7:0] D_UNLK2 = 8'h55;
  localparam logic [7:0] D_ERASE_SETUP = 8'h80;
  localparam logic [7:0] D_CHIP_ERASE = 8'h10;
  localparam logic [7:0] D_SECT_ERASE = 8'h30;
  localparam logic [7:0] D_LOCKDOWN = 8'h60;
  localparam logic [7:0] D_PROGRAM = 8'hA0;
  localparam logic [7:0] D_DUAL = 8'hE0;
  localparam logic [7:0] D_PROT = 8'hC0;
  localparam logic [7:0] D_IDENT = 8'h90;
  localparam logic [7:0] D_EXIT = 8'hF0;
  localparam logic [7:0] D_SUSPEND = 8'hB0;
  localparam logic [7:0] D_RESUME = 8'h30;
  localparam logic [7:0] D_CONFIG = 8'hD0;
  localparam logic [7:0] D_QUERY = 8'h98;
  localparam logic [15:0] D_LOCK_PROT = 16'h0000;

  // ==========================================================================
  // Protection register map: A7 set, one-based word index on A3..A0
  localparam logic [19:0] PROT_BASE = 20'h00080;
  localparam int PROT_WORDS = 8;
  localparam int PROT_USER_FIRST = 4;
  localparam int LOCK_BIT = 1;

  // ==========================================================================
  // Bus timing in ns, turned into cycles at the system clock
  localparam int CLK_NS = 20;
  localparam int T_SETUP_NS = 30;
  localparam int T_PULSE_NS = 40;
  localparam int T_HOLD_NS = 30;
  localparam int T_READ_NS = 70;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYC = (T_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int MAX_CYCLES = 6;

  typedef enum logic [3:0] {
    OP_READ, OP_CHIP_ERASE, OP_SECT_ERASE, OP_PROGRAM, OP_DUAL_PROGRAM,
    OP_SINGLE_PULSE_ENTER, OP_SINGLE_PULSE_WRITE, OP_LOCKDOWN, OP_SUSPEND,
    OP_RESUME, OP_IDENT_ENTER, OP_IDENT_EXIT, OP_PROT_PROGRAM, OP_PROT_LOCK,
    OP_LOCK_STATUS, OP_SET_CONFIG
  } fcs_op_t;

  typedef struct packed {
    fcs_op_t op;
    logic [19:0] addr;
    logic [15:0] data;
    logic [19:0] second_pair_address;
    logic [15:0] data2;
    logic shortExit;
  } fcs_req_t;

  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] data;
    logic wr;
  } fcs_cycle_t;

endpackage : fcs_pkg

//--- logic/fcs_host.sv
`timescale 1ns/10ps
// Functional notes
// [R01] Word mode: low byte, A11..A0 compared; the flash model compares A10..A0 only
// [R02] Byte mode: A19..A11 and A-1 ignored
// [R03] Commands other than suspend, resume and single F0 open AA@555, 55@AAA; query 98@55 and single-pulse writes go out without them
// [R04] Sector erase 30, lockdown 60 at sector
// [R05] Locked sector refuses changes until reset
// [R06] Identification exit: three-cycle or single F0
// [R07] Other exit bytes accepted; F0 preferred
// [R08] Lock status read at 80, D1
// [R09] Configuration set: D0@555 then 00/01
// [R10] Dual program addresses differ in A0
// [R11] Dual program for manufacturing use only
// [R12] Protection access drives A19..A8 zero
// [R13] Protection words at 81..88
// [R14] Six cycles enter single-pulse program mode
// [R15] Lock user block: C0 then 080
// [R16] Chip erase, program, protection program codes
// [R17] Suspend B0, resume 30, ident 90, query 98
// [R18] Block lock cycle drives D1 zero
// [R19] Exit identification after protection reads
// [R20] Query enters from read or identification
module fcs_host #(
  parameter int ADDR_WIDTH = fcs_pkg::ADDR_W,
  parameter int DATA_WIDTH = fcs_pkg::DATA_W
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire fcs_pkg::fcs_req_t reqIn,
  input wire logic reqValid,
  output logic reqReady,
  output logic [15:0] rdData,
  output logic rdValid,
  output logic errDual,
  output logic [19:0] flashAddr,
  output logic [15:0] flashDataOut,
  output logic flashDataOe,
  input wire logic [15:0] flashDataIn,
  output logic flashWeN,
  output logic flashOeN,
  output logic flashCeN
);
  import fcs_pkg::*;

  // Ports are fixed at the documented bus, so other widths are refused at elaboration
  if (ADDR_WIDTH != ADDR_W || DATA_WIDTH != DATA_W) begin : g_width_check
    $error("fcs_host supports only a 20-bit address and 16-bit data bus");
  end

  // ==========================================================================
  // Sequence builder
  function automatic fcs_cycle_t cyc(input logic [19:0] a, input logic [15:0] d,
                                     input logic w);
    cyc.addr = a;
    cyc.data = d;
    cyc.wr = w;
  endfunction : cyc

  function automatic logic [19:0] protAddr(input logic [19:0] a);
    // Word select only; upper lines forced low  // see [R12] see [R13]
    protAddr = PROT_BASE | {16'h0000, a[3:0]};
  endfunction : protAddr

  typedef enum {S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_READ, S_NEXT} fcs_state_t;

  fcs_state_t state_r;
  fcs_cycle_t seq_r [MAX_CYCLES];
  fcs_cycle_t seqNxt [MAX_CYCLES];
  logic [2:0] seqLen_r;
  logic [2:0] seqLenNxt;
  logic [2:0] idx_r;
  logic [3:0] cnt_r;
  logic [15:0] dinS1_r;
  logic [15:0] dinS2_r;
  logic identMode_r;

  always_comb begin
    fcs_cycle_t u1;
    fcs_cycle_t u2;
    u1 = cyc(A_UNLK1, {8'h00, D_UNLK1}, 1'b1);  // see [R03]
    u2 = cyc(A_UNLK2, {8'h00, D_UNLK2}, 1'b1);  // see [R03]
    for (int i = 0; i < MAX_CYCLES; i++) begin
      seqNxt[i] = cyc(A_ZERO, 16'h0000, 1'b0);
    end
    seqNxt[0] = u1;
    seqNxt[1] = u2;
    seqLenNxt = 3'd3;
    case (reqIn.op)
      OP_READ: begin
        seqNxt[0] = cyc(reqIn.addr, 16'h0000, 1'b0);
        seqLenNxt = 3'd1;
      end
      OP_CHIP_ERASE, OP_SECT_ERASE, OP_LOCKDOWN, OP_SINGLE_PULSE_ENTER: begin
        seqNxt[2] = cyc(A_UNLK1, {8'h00, D_ERASE_SETUP}, 1'b1);
        seqNxt[3] = u1;
        seqNxt[4] = u2;
        seqLenNxt = 3'd6;
        case (reqIn.op)
          OP_CHIP_ERASE: seqNxt[5] = cyc(A_UNLK1, {8'h00, D_CHIP_ERASE}, 1'b1);  // see [R16]
          OP_SECT_ERASE: seqNxt[5] = cyc(reqIn.addr, {8'h00, D_SECT_ERASE}, 1'b1);  // see [R04]
          OP_LOCKDOWN: seqNxt[5] = cyc(reqIn.addr, {8'h00, D_LOCKDOWN}, 1'b1);  // see [R04]
          default: seqNxt[5] = cyc(A_UNLK1, {8'h00, D_PROGRAM}, 1'b1);  // see [R14]
        endcase
      end
      OP_PROGRAM: begin
        seqNxt[2] = cyc(A_UNLK1, {8'h00, D_PROGRAM}, 1'b1);  // see [R16]
        seqNxt[3] = cyc(reqIn.addr, reqIn.data, 1'b1);
        seqLenNxt = 3'd4;
      end
      OP_DUAL_PROGRAM: begin
        seqNxt[2] = cyc(A_UNLK1, {8'h00, D_DUAL}, 1'b1);  // see [R10] see [R11]
        seqNxt[3] = cyc(reqIn.addr, reqIn.data, 1'b1);
        seqNxt[4] = cyc(reqIn.second_pair_address, reqIn.data2, 1'b1);
        seqLenNxt = 3'd5;
      end
      OP_SINGLE_PULSE_WRITE: begin
        seqNxt[0] = cyc(reqIn.addr, reqIn.data, 1'b1);  // see [R14]
        seqLenNxt = 3'd1;
      end
      OP_SUSPEND: begin
        seqNxt[0] = cyc(reqIn.addr, {8'h00, D_SUSPEND}, 1'b1);  // see [R17]
        seqLenNxt = 3'd1;
      end
      OP_RESUME: begin
        seqNxt[0] = cyc(reqIn.addr, {8'h00, D_RESUME}, 1'b1);  // see [R17]
        seqLenNxt = 3'd1;
      end
      OP_IDENT_ENTER: seqNxt[2] = cyc(A_UNLK1, {8'h00, D_IDENT}, 1'b1);  // see [R17]
      OP_IDENT_EXIT: begin
        if (reqIn.shortExit) begin
          seqNxt[0] = cyc(reqIn.addr, {8'h00, D_EXIT}, 1'b1);  // see [R06] see [R07]
          seqLenNxt = 3'd1;
        end else begin
          seqNxt[2] = cyc(A_UNLK1, {8'h00, D_EXIT}, 1'b1);  // see [R06]
        end
      end
      OP_PROT_PROGRAM: begin
        seqNxt[2] = cyc(A_UNLK1, {8'h00, D_PROT}, 1'b1);  // see [R16]
        seqNxt[3] = cyc(protAddr(reqIn.addr), reqIn.data, 1'b1);
        seqLenNxt = 3'd4;
      end
      OP_PROT_LOCK: begin
        seqNxt[2] = cyc(A_UNLK1, {8'h00, D_PROT}, 1'b1);  // see [R15]
        seqNxt[3] = cyc(A_LOCKSTAT, D_LOCK_PROT, 1'b1);  // see [R18]
        seqLenNxt = 3'd4;
      end
      OP_LOCK_STATUS: begin
        seqNxt[2] = cyc(A_UNLK1, {8'h00, D_IDENT}, 1'b1);  // see [R08]
        seqNxt[3] = cyc(A_LOCKSTAT, 16'h0000, 1'b0);
        seqLenNxt = 3'd4;
      end
      OP_SET_CONFIG: begin
        seqNxt[2] = cyc(A_UNLK1, {8'h00, D_CONFIG}, 1'b1);  // see [R09]
        seqNxt[3] = cyc(reqIn.addr, {15'h0000, reqIn.data[0]}, 1'b1);
        seqLenNxt = 3'd4;
      end
      default: seqLenNxt = 3'd1;
    endcase
    // Query write is a single cycle folded into the read op with addr 55
    if (reqIn.op == OP_READ && reqIn.shortExit) begin
      seqNxt[0] = cyc(A_QUERY, {8'h00, D_QUERY}, 1'b1);  // see [R17] see [R20]
    end
  end

  // ==========================================================================
  // Bus cycle sequencer
  assign reqReady = (state_r == S_IDLE);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= S_IDLE;
      seqLen_r <= 3'd0;
      idx_r <= 3'd0;
      cnt_r <= 4'd0;
      for (int i = 0; i < MAX_CYCLES; i++) begin
        seq_r[i] <= '0;
      end
    end else begin
      case (state_r)
        S_IDLE: begin
          if (reqValid) begin
            seq_r <= seqNxt;
            seqLen_r <= seqLenNxt;
            idx_r <= 3'd0;
            cnt_r <= 4'(SETUP_CYC);
            state_r <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (cnt_r <= 4'd1) begin
            cnt_r <= seq_r[idx_r].wr ? 4'(PULSE_CYC) : 4'(READ_CYC);
            state_r <= seq_r[idx_r].wr ? S_PULSE : S_READ;
          end else begin
            cnt_r <= cnt_r - 4'd1;
          end
        end
        S_PULSE, S_READ: begin
          if (cnt_r <= 4'd1) begin
            cnt_r <= 4'(HOLD_CYC);
            state_r <= S_HOLD;
          end else begin
            cnt_r <= cnt_r - 4'd1;
          end
        end
        S_HOLD: begin
          if (cnt_r <= 4'd1) begin
            state_r <= S_NEXT;
          end else begin
            cnt_r <= cnt_r - 4'd1;
          end
        end
        S_NEXT: begin
          if (idx_r + 3'd1 >= seqLen_r) begin
            state_r <= S_IDLE;
          end else begin
            idx_r <= idx_r + 3'd1;
            cnt_r <= 4'(SETUP_CYC);
            state_r <= S_SETUP;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Pin drive; strobes registered so they are glitch free
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flashAddr <= 20'h00000;
      flashDataOut <= 16'h0000;
      flashDataOe <= 1'b0;
      flashWeN <= 1'b1;
      flashOeN <= 1'b1;
      flashCeN <= 1'b1;
    end else begin
      flashAddr <= seq_r[idx_r].addr;
      flashDataOut <= seq_r[idx_r].data;
      flashDataOe <= (state_r != S_IDLE) && (state_r != S_NEXT) && seq_r[idx_r].wr;
      flashCeN <= (state_r == S_IDLE) || (state_r == S_NEXT);
      flashWeN <= !(state_r == S_PULSE);
      flashOeN <= !(state_r == S_READ);
    end
  end

  // ==========================================================================
  // Read data capture; data pins come from outside, so double-register them
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dinS1_r <= 16'h0000;
      dinS2_r <= 16'h0000;
    end else begin
      dinS1_r <= flashDataIn;
      dinS2_r <= dinS1_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdData <= 16'h0000;
      rdValid <= 1'b0;
    end else begin
      rdValid <= 1'b0;
      if (state_r == S_HOLD && cnt_r <= 4'd1 && !seq_r[idx_r].wr) begin
        rdData <= dinS2_r;  // see [R08] bit LOCK_BIT low means locked
        rdValid <= 1'b1;
      end
    end
  end

  // Tracks identification mode; no output or check reads the flag
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      identMode_r <= 1'b0;
    end else if (reqValid && reqReady) begin
      if (reqIn.op == OP_IDENT_ENTER || reqIn.op == OP_LOCK_STATUS) begin
        identMode_r <= 1'b1;  // see [R19]
      end else if (reqIn.op == OP_IDENT_EXIT) begin
        identMode_r <= 1'b0;
      end
    end
  end

  // Dual program pair check: flagged, not blocked
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      errDual <= 1'b0;
    end else if (reqValid && reqReady) begin
      errDual <= (reqIn.op == OP_DUAL_PROGRAM) &&
                 ((reqIn.addr ^ reqIn.second_pair_address) != 20'h00001);  // see [R10]
    end
  end

endmodule : fcs_host

//--- tb/fcs_flash_model.sv
`timescale 1ns/10ps
module fcs_flash_model (
  input wire logic sys_clk,
  input wire logic [19:0] flashAddr,
  input wire logic [15:0] flashDataOut,
  input wire logic flashDataOe,
  input wire logic flashWeN,
  input wire logic flashOeN,
  input wire logic flashCeN,
  output logic [15:0] flashDataIn
);
  localparam logic [15:0] FACTORY_BASE = 16'h1000;
  logic [19:0] wA[$];
  logic [15:0] wD[$];
  logic [15:0] prot[8];
  logic [18:0] h0 = '0;
  logic [18:0] h1 = '0;
  logic idMode = 1'b0;
  logic userLock = 1'b0;
  logic protArm = 1'b0;
  logic progArm = 1'b0;
  logic [5:0] lockSect = '0;
  int refused = 0;
  logic [15:0] noise = 16'h1234;
  wire [10:0] a = flashAddr[10:0];
  wire [7:0] d = flashDataOut[7:0];
  wire pre = h1 == {11'h555, 8'hAA} && h0 == {11'h2AA, 8'h55};
  initial for (int i = 0; i < 8; i++) prot[i] = FACTORY_BASE + 16'(i);
  // Released bus has no pull: show a moving pattern, never the last value
  always @(posedge sys_clk) noise <= noise + 16'h3C5B;
  // ==========================================================================
  // Command decode on the write strobe's rising edge
  always @(posedge flashWeN) if (!flashCeN) begin
    wA.push_back(flashAddr);
    wD.push_back(flashDataOut);
    h1 <= h0;
    h0 <= {a, d};
    protArm <= pre && a == 11'h555 && d == 8'hC0;
    progArm <= pre && a == 11'h555 && d == 8'hA0;
    // Sector key is A19..A15 only, so the small boot sectors share one key
    if (pre && d == 8'h60) lockSect <= {1'b1, flashAddr[19:15]};
    if (progArm && lockSect == {1'b1, flashAddr[19:15]}) refused++;
    if (pre && a == 11'h555 && d == 8'h90) idMode <= 1'b1;
    else if (idMode && d != 8'hAA && d != 8'h55) idMode <= 1'b0;
    if (protArm && flashAddr == 20'h00080) userLock <= 1'b1;
    else if (protArm && !userLock && flashAddr[7] && flashAddr[3:0] > 4'h4 &&
        flashAddr[3:0] < 4'h9)
      prot[flashAddr[3:0] - 4'h1] <= flashDataOut;
  end
  always_comb
    if (flashDataOe) flashDataIn = flashDataOut;
    else if (flashCeN || flashOeN) flashDataIn = noise;
    else if (!idMode) flashDataIn = ~flashAddr[15:0];
    else if (flashAddr[7:0] == 8'h80) flashDataIn = {14'h0, ~userLock, 1'b1};
    else flashDataIn = prot[flashAddr[3:0] - 4'h1];
endmodule : fcs_flash_model

//--- tb/fcs_host_chk.sv
`timescale 1ns/10ps
module fcs_host_chk (
  input wire logic sys_clk,
  input wire logic reset,
  input wire fcs_pkg::fcs_req_t reqIn,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic errDual,
  input wire logic [19:0] flashAddr,
  input wire logic [15:0] flashDataOut,
  input wire logic flashDataOe,
  input wire logic flashWeN,
  input wire logic flashOeN,
  input wire logic flashCeN
);
  import fcs_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire take = reqValid && reqReady;
  wire dual = take && reqIn.op == OP_DUAL_PROGRAM;
  sequence unlock_first;
    $fell(flashWeN) && flashAddr[10:0] == 11'h555 && flashDataOut[7:0] == 8'hAA;
  endsequence
  sequence write_pulse;
    !flashWeN ##1 flashWeN;
  endsequence
  // ==========================================================================
  // Bus cycle shape, request handshake, command openings and dual pair flag
  take_busy_a: assert property (take |=> !reqReady)
    else $error("request taken but still ready");
  write_qual_a: assert property (!flashWeN |-> flashDataOe && !flashCeN && flashOeN)
    else $error("write pulse without drive or select");
  read_qual_a: assert property (!flashOeN |-> !flashDataOe && !flashCeN)
    else $error("read strobe while driving data");
  write_width_a: assert property ($fell(flashWeN) |=> write_pulse)
    else $error("write pulse not two cycles");
  read_width_a: assert property ($fell(flashOeN) |=> !flashOeN [*3] ##1 flashOeN)
    else $error("read strobe not four cycles");
  addr_stable_a: assert property (!flashWeN |-> $stable(flashAddr) &&
    $stable(flashDataOut))
    else $error("address or data moved under write pulse");
  unlock_open_a: assert property (take && reqIn.op == OP_PROGRAM |->
    ##[1:8] unlock_first)
    else $error("program did not open with unlock cycle");
  query_one_a: assert property (take && reqIn.op == OP_READ && reqIn.shortExit |->
    ##[1:8] ($fell(flashWeN) && flashAddr[7:0] == 8'h55 && flashDataOut[7:0] == 8'h98))
    else $error("query entry write missing");
  dual_ok_a: assert property (dual && (reqIn.addr ^ reqIn.second_pair_address) == 20'h00001 |->
    ##3 !errDual)
    else $error("dual error on valid pair");
  dual_bad_a: assert property (dual && (reqIn.addr ^ reqIn.second_pair_address) != 20'h00001 |->
    ##3 errDual)
    else $error("dual error missing on bad pair");
endmodule : fcs_host_chk
bind fcs_host fcs_host_chk u_chk (.sys_clk(sys_clk), .reset(reset), .reqIn(reqIn),
  .reqValid(reqValid), .reqReady(reqReady), .errDual(errDual), .flashAddr(flashAddr),
  .flashDataOut(flashDataOut), .flashDataOe(flashDataOe), .flashWeN(flashWeN),
  .flashOeN(flashOeN), .flashCeN(flashCeN));

//--- tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin nChecks++; if ((g) !== (e)) begin numErrors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_top;
  import fcs_pkg::*;
  localparam fcs_op_t SIX[4] = '{OP_CHIP_ERASE, OP_SECT_ERASE, OP_LOCKDOWN, OP_SINGLE_PULSE_ENTER};
  localparam logic [7:0] SIX_D[4] = '{8'h10, 8'h30, 8'h60, 8'hA0};
  localparam fcs_op_t ONE[4] = '{OP_SUSPEND, OP_RESUME, OP_SINGLE_PULSE_WRITE, OP_IDENT_EXIT};
  localparam logic [7:0] ONE_D[4] = '{8'hB0, 8'h30, 8'h3C, 8'hF0};
  localparam fcs_op_t TRI[3] = '{OP_IDENT_ENTER, OP_IDENT_EXIT, OP_SET_CONFIG};
  localparam logic [7:0] TRI_D[3] = '{8'h90, 8'hF0, 8'hD0};
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic reqValid = 1'b0;
  fcs_req_t reqIn = '0;
  logic reqReady, rdValid, errDual, flashDataOe, flashWeN, flashOeN, flashCeN;
  logic [15:0] rdData, flashDataOut, flashDataIn, got;
  logic [19:0] flashAddr;
  int numErrors = 0;
  int nChecks = 0;
  int base;
  always #10 sys_clk = ~sys_clk;
  fcs_host DUT (.sys_clk(sys_clk), .reset(reset), .reqIn(reqIn), .reqValid(reqValid),
    .reqReady(reqReady), .rdData(rdData), .rdValid(rdValid), .errDual(errDual),
    .flashAddr(flashAddr), .flashDataOut(flashDataOut), .flashDataOe(flashDataOe),
    .flashDataIn(flashDataIn), .flashWeN(flashWeN), .flashOeN(flashOeN), .flashCeN(flashCeN));
  fcs_flash_model FM (.sys_clk(sys_clk), .flashAddr(flashAddr), .flashDataOut(flashDataOut),
    .flashDataOe(flashDataOe), .flashWeN(flashWeN), .flashOeN(flashOeN), .flashCeN(flashCeN),
    .flashDataIn(flashDataIn));
  task automatic giveVerdict;
    $display("errors %0d checks %0d", numErrors, nChecks);
    if (numErrors == 0 && nChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : giveVerdict
  // ==========================================================================
  // One request: held from just after an edge until taken, then waited out
  task automatic run(input fcs_op_t op, input logic [19:0] a, input logic [15:0] d,
      input logic [19:0] a2 = 20'h00000, input logic [15:0] d2 = 16'h0000, input logic sx = 1'b0);
    int i;
    base = FM.wA.size();
    got = 16'hxxxx;
    reqIn = '{op, a, d, a2, d2, sx};
    reqValid = 1'b1;
    @(posedge sys_clk);
    #1 reqValid = 1'b0;
    i = 0;
    do begin
      @(posedge sys_clk);
      #1 i++;
      if (rdValid === 1'b1) got = rdData;
    end while (reqReady !== 1'b1 && i < 600);
    if (i >= 600) begin
      numErrors++;
      giveVerdict();
    end
  endtask : run
  task automatic wr(input int k, input logic [19:0] a, input logic [15:0] d, input bit full);
    if (full) `CHK("cycle", {a, d}, {FM.wA[base + k], FM.wD[base + k]})
    else `CHK("cmd cycle", {a[10:0], d[7:0]}, {FM.wA[base + k][10:0], FM.wD[base + k][7:0]})
  endtask : wr
  task automatic unl(input int k);
    wr(k, 20'h00555, 16'h00AA, 0);
    wr(k + 1, 20'h00AAA, 16'h0055, 0);
  endtask : unl
  task automatic cnt(input int n);
    `CHK("cycle count", n, FM.wA.size() - base)
  endtask : cnt
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 reset = 1'b0;
    run(OP_PROGRAM, 20'h12345, 16'hBEEF);
    unl(0);
    wr(2, 20'h00555, 16'h00A0, 0);
    wr(3, 20'h12345, 16'hBEEF, 1);
    cnt(4);
    `CHK("refused count", 0, FM.refused)
    for (int j = 0; j < 4; j++) begin
      run(SIX[j], 20'h41234, 16'h0000);
      unl(0);
      wr(2, 20'h00555, 16'h0080, 0);
      unl(3);
      wr(5, j == 1 || j == 2 ? 20'h41234 : 20'h00555, {8'h00, SIX_D[j]}, 0);
      cnt(6);
    end
    // The lockdown above covers this sector, so the device must refuse the program
    run(OP_PROGRAM, 20'h41000, 16'h5A5A);
    `CHK("refused count", 1, FM.refused)
    for (int j = 0; j < 4; j++) begin
      run(ONE[j], 20'h0F00F, j == 2 ? 16'h1E3C : 16'h0000, 20'h00000, 16'h0000, j == 3);
      `CHK("single cycle", ONE_D[j], FM.wD[base][7:0])
      cnt(1);
    end
    for (int j = 0; j < 3; j++) begin
      run(TRI[j], 20'h00000, 16'h0001);
      unl(0);
      wr(2, 20'h00555, {8'h00, TRI_D[j]}, 0);
      cnt(j == 2 ? 4 : 3);
    end
    `CHK("config value", 8'h01, FM.wD[base + 3][7:0])
    run(OP_DUAL_PROGRAM, 20'h00100, 16'h1111, 20'h00101, 16'h2222);
    wr(2, 20'h00555, 16'h00E0, 0);
    wr(3, 20'h00100, 16'h1111, 1);
    wr(4, 20'h00101, 16'h2222, 1);
    `CHK("dual error", 1'b0, errDual)
    run(OP_DUAL_PROGRAM, 20'h00100, 16'h1111, 20'h00102, 16'h2222);
    `CHK("dual error", 1'b1, errDual)
    run(OP_PROT_PROGRAM, 20'h00005, 16'h1234);
    wr(2, 20'h00555, 16'h00C0, 0);
    wr(3, 20'h00085, 16'h1234, 1);
    run(OP_LOCK_STATUS, 20'h00000, 16'h0000);
    `CHK("unlocked bit", 1'b1, got[1])
    run(OP_IDENT_EXIT, 20'h00000, 16'h0000, 20'h00000, 16'h0000, 1'b1);
    run(OP_PROT_LOCK, 20'h00000, 16'h0000);
    wr(3, 20'h00080, 16'h0000, 1);
    run(OP_LOCK_STATUS, 20'h00000, 16'h0000);
    `CHK("locked bit", 1'b0, got[1])
    run(OP_READ, 20'h00085, 16'h0000);
    `CHK("user word", 16'h1234, got)
    run(OP_IDENT_EXIT, 20'h00000, 16'h0000, 20'h00000, 16'h0000, 1'b1);
    run(OP_READ, 20'h00123, 16'h0000);
    `CHK("array read", 16'hFEDC, got)
    run(OP_READ, 20'h00123, 16'h0000, 20'h00000, 16'h0000, 1'b1);
    wr(0, 20'h00055, 16'h0098, 0);
    giveVerdict();
  end
endmodule : tb_top
